//--- adrr_defines.svh
// adrr_defines.svh: named offsets, field positions, codes and reset values
// of the input range register bank; definitions only, included by bare name.
`ifndef ADRR_DEFINES_SVH
`define ADRR_DEFINES_SVH

// access word layout
`define ADRR_ACC_W 16
`define ADRR_ADDR_MSB 15
`define ADRR_ADDR_LSB 9
`define ADRR_ADDR_W 7
`define ADRR_RSVD_BIT 8
`define ADRR_DATA_W 9
`define ADRR_FIELDS_W 8

// register addresses
`define ADRR_ADDR_A_LOW 7'h04
`define ADRR_ADDR_A_HIGH 7'h05
`define ADRR_ADDR_B_LOW 7'h06
`define ADRR_ADDR_B_HIGH 7'h07

// bank shape
`define ADRR_NUM_REGS 4
`define ADRR_IDX_W 2
`define ADRR_CH_PER_REG 4
`define ADRR_NUM_CH 16
`define ADRR_CH_PER_CONV 8
`define ADRR_FIELD_W 2

// reset values
`define ADRR_REG_RESET 9'h0FF
`define ADRR_FIELD_RESET 2'h3

// range field codes
`define ADRR_CODE_10V_LO 2'h0
`define ADRR_CODE_2P5V 2'h1
`define ADRR_CODE_5V 2'h2
`define ADRR_CODE_10V_HI 2'h3

`endif

//--- adrr_pkg.sv
// adrr_pkg.sv: types of the input range register bank.
// assumes adrr_defines.svh sits in the same folder.
`include "adrr_defines.svh"

package adrr_pkg;

    // the three selectable input spans
    typedef enum logic [1:0] {
        ADRR_RNG_10V = 2'b00,
        ADRR_RNG_5V = 2'b01,
        ADRR_RNG_2P5V = 2'b10
    } adrr_range_t;

    typedef struct packed {
        logic [`ADRR_NUM_REGS-1:0][`ADRR_DATA_W-1:0] word;
        logic [`ADRR_DATA_W-1:0] rdata;
    } adrr_mem_state_t;

    typedef struct packed {
        logic rd_pend;
        logic [`ADRR_ADDR_W-1:0] rd_addr;
        logic rd_valid;
        logic [`ADRR_ACC_W-1:0] rd_word;
        logic wr_ack;
        adrr_range_t [`ADRR_NUM_CH-1:0] range;
        logic changed;
    } adrr_top_state_t;

endpackage

//--- adrr_regmem.sv
// adrr_regmem.sv: four 9-bit range words with one write and one read port.
// assumes single clock; read data come out of a register, read-before-write.
`timescale 1ns/100ps
`include "adrr_defines.svh"

module adrr_regmem (
    input wire logic clock_i, // interface clock
    input wire logic rst_i, // async reset, active high
    input wire logic ce_i, // clock enable
    input wire logic wr_en_i, // write strobe
    input wire logic [`ADRR_IDX_W-1:0] wr_idx_i, // word written
    input wire logic [`ADRR_DATA_W-1:0] wr_data_i, // bits 8..0 to store
    input wire logic [`ADRR_IDX_W-1:0] rd_idx_i, // word read
    output logic [`ADRR_DATA_W-1:0] rd_data_o, // registered read data
    output logic [`ADRR_NUM_REGS*`ADRR_FIELDS_W-1:0] fields_o // range fields of all words
);

    adrr_pkg::adrr_mem_state_t st_reg;
    adrr_pkg::adrr_mem_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rdata = st_reg.word[rd_idx_i];
        if (wr_en_i) begin
            st_next.word[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `ADRR_NUM_REGS; i++) begin
                st_reg.word[i] <= `ADRR_REG_RESET;
            end
            st_reg.rdata <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o = st_reg.rdata;

    generate
        for (genvar r = 0; r < `ADRR_NUM_REGS; r++) begin : g_fld
            assign fields_o[r*`ADRR_FIELDS_W +: `ADRR_FIELDS_W] =
                st_reg.word[r][`ADRR_FIELDS_W-1:0];
        end
    endgenerate

endmodule

//--- adrr_range_regs.sv
// adrr_range_regs.sv: input range register bank, four 16-bit words that
// select the span of each of the sixteen analog inputs of both converters.
// assumes the interface logic hands over one decoded access word per strobe
// on this clock; framing and the other registers live elsewhere.
`timescale 1ns/100ps
`include "adrr_defines.svh"

// Notes on behaviour
// - converter A inputs 0-3 at 0x04, reset 0x00FF
// - converter A inputs 4-7 at 0x05, reset 0x00FF
// - converter B inputs 0-3 at 0x06, reset 0x00FF
// - converter B inputs 4-7 at 0x07, reset 0x00FF
// - highest channel in bits 7:6, lowest 1:0
// - code 00/11 ten volts, 01 2.5, 10 five
// - every field resets to 3, ten volt span
// - bits 15:9 address, bit 8 reserved storage
// - three spans, chosen per channel independently
module adrr_range_regs (
    input wire logic clock_i, // interface clock, 200 MHz
    input wire logic rst_i, // async reset, active high
    input wire logic ce_i, // clock enable, freezes all state when low
    input wire logic acc_valid_i, // one access word offered
    input wire logic acc_write_i, // 1 write, 0 read
    input wire logic [`ADRR_ACC_W-1:0] acc_word_i, // address 15:9, data 8:0
    output logic rd_valid_o, // read answer strobe
    output logic [`ADRR_ACC_W-1:0] rd_word_o, // read answer word
    output logic wr_ack_o, // write stored strobe
    output logic range_changed_o, // some span changed
    output logic [1:0] conv_a_in0_range_o, // span of converter A input 0
    output logic [1:0] conv_a_in1_range_o, // span of converter A input 1
    output logic [1:0] conv_a_in2_range_o, // span of converter A input 2
    output logic [1:0] conv_a_in3_range_o, // span of converter A input 3
    output logic [1:0] conv_a_in4_range_o, // span of converter A input 4
    output logic [1:0] conv_a_in5_range_o, // span of converter A input 5
    output logic [1:0] conv_a_in6_range_o, // span of converter A input 6
    output logic [1:0] conv_a_in7_range_o, // span of converter A input 7
    output logic [1:0] conv_b_in0_range_o, // span of converter B input 0
    output logic [1:0] conv_b_in1_range_o, // span of converter B input 1
    output logic [1:0] conv_b_in2_range_o, // span of converter B input 2
    output logic [1:0] conv_b_in3_range_o, // span of converter B input 3
    output logic [1:0] conv_b_in4_range_o, // span of converter B input 4
    output logic [1:0] conv_b_in5_range_o, // span of converter B input 5
    output logic [1:0] conv_b_in6_range_o, // span of converter B input 6
    output logic [1:0] conv_b_in7_range_o // span of converter B input 7
);

    adrr_pkg::adrr_top_state_t st_reg;
    adrr_pkg::adrr_top_state_t st_next;

    logic [`ADRR_ADDR_W-1:0] target_reg_field;
    logic [`ADRR_DATA_W-1:0] acc_data;
    logic addr_hit;
    logic [`ADRR_IDX_W-1:0] acc_idx;
    logic mem_wr_en;
    logic [`ADRR_DATA_W-1:0] mem_rd_data;
    logic [`ADRR_NUM_REGS*`ADRR_FIELDS_W-1:0] mem_fields;
    adrr_pkg::adrr_range_t [`ADRR_NUM_CH-1:0] range_dec;

    // three spans, with both ten volt codes folded together
    function automatic adrr_pkg::adrr_range_t decode_span(input logic [1:0] code);
        adrr_pkg::adrr_range_t span;
        span = adrr_pkg::ADRR_RNG_10V;
        unique case (code)
            `ADRR_CODE_10V_LO: span = adrr_pkg::ADRR_RNG_10V;
            `ADRR_CODE_2P5V: span = adrr_pkg::ADRR_RNG_2P5V;
            `ADRR_CODE_5V: span = adrr_pkg::ADRR_RNG_5V;
            `ADRR_CODE_10V_HI: span = adrr_pkg::ADRR_RNG_10V;
        endcase
        return span;
    endfunction

    // split the access word
    assign target_reg_field = acc_word_i[`ADRR_ADDR_MSB:`ADRR_ADDR_LSB];
    assign acc_data = acc_word_i[`ADRR_DATA_W-1:0];

    // the four words sit on consecutive addresses
    assign addr_hit = (target_reg_field == `ADRR_ADDR_A_LOW)
                    || (target_reg_field == `ADRR_ADDR_A_HIGH)
                    || (target_reg_field == `ADRR_ADDR_B_LOW)
                    || (target_reg_field == `ADRR_ADDR_B_HIGH);
    assign acc_idx = `ADRR_IDX_W'(target_reg_field - `ADRR_ADDR_A_LOW);

    // unmapped addresses belong to other registers and are left alone
    assign mem_wr_en = acc_valid_i && acc_write_i && addr_hit;

    adrr_regmem u_mem (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_en_i(mem_wr_en),
        .wr_idx_i(acc_idx),
        .wr_data_i(acc_data),
        .rd_idx_i(acc_idx),
        .rd_data_o(mem_rd_data),
        .fields_o(mem_fields)
    );

    // channel g lives in word g/4, field g%4; higher channel in higher bits
    generate
        for (genvar g = 0; g < `ADRR_NUM_CH; g++) begin : g_ch
            localparam int REG_I = g / `ADRR_CH_PER_REG;
            localparam int FLD_I = g % `ADRR_CH_PER_REG;
            localparam int LSB = REG_I * `ADRR_FIELDS_W + FLD_I * `ADRR_FIELD_W;
            assign range_dec[g] = decode_span(mem_fields[LSB +: `ADRR_FIELD_W]);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.rd_pend = acc_valid_i && !acc_write_i && addr_hit;
        st_next.rd_addr = target_reg_field;
        st_next.wr_ack = mem_wr_en;
        st_next.rd_valid = st_reg.rd_pend;
        if (st_reg.rd_pend) begin
            // echo the address; reserved bit and fields as stored
            st_next.rd_word = {st_reg.rd_addr, mem_rd_data};
        end
        st_next.range = range_dec;
        st_next.changed = (range_dec != st_reg.range);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg.rd_pend <= 1'b0;
            st_reg.rd_addr <= '0;
            st_reg.rd_valid <= 1'b0;
            st_reg.rd_word <= '0;
            st_reg.wr_ack <= 1'b0;
            for (int i = 0; i < `ADRR_NUM_CH; i++) begin
                st_reg.range[i] <= adrr_pkg::ADRR_RNG_10V;
            end
            st_reg.changed <= 1'b0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign rd_valid_o = st_reg.rd_valid;
    assign rd_word_o = st_reg.rd_word;
    assign wr_ack_o = st_reg.wr_ack;
    assign range_changed_o = st_reg.changed;

    assign conv_a_in0_range_o = st_reg.range[0];
    assign conv_a_in1_range_o = st_reg.range[1];
    assign conv_a_in2_range_o = st_reg.range[2];
    assign conv_a_in3_range_o = st_reg.range[3];
    assign conv_a_in4_range_o = st_reg.range[4];
    assign conv_a_in5_range_o = st_reg.range[5];
    assign conv_a_in6_range_o = st_reg.range[6];
    assign conv_a_in7_range_o = st_reg.range[7];
    assign conv_b_in0_range_o = st_reg.range[`ADRR_CH_PER_CONV+0];
    assign conv_b_in1_range_o = st_reg.range[`ADRR_CH_PER_CONV+1];
    assign conv_b_in2_range_o = st_reg.range[`ADRR_CH_PER_CONV+2];
    assign conv_b_in3_range_o = st_reg.range[`ADRR_CH_PER_CONV+3];
    assign conv_b_in4_range_o = st_reg.range[`ADRR_CH_PER_CONV+4];
    assign conv_b_in5_range_o = st_reg.range[`ADRR_CH_PER_CONV+5];
    assign conv_b_in6_range_o = st_reg.range[`ADRR_CH_PER_CONV+6];
    assign conv_b_in7_range_o = st_reg.range[`ADRR_CH_PER_CONV+7];

endmodule

//--- adrr_range_regs_properties.sv
// adrr_range_regs_properties.sv: port checks of the range register bank.
// assumes one clock, async active-high reset; bound from the bench.
`timescale 1ns/100ps
module adrr_range_regs_properties (
    input wire logic clock_i, // clock
    input wire logic rst_i, // reset
    input wire logic ce_i, // enable
    input wire logic acc_valid_i, // access
    input wire logic acc_write_i, // write
    input wire logic [15:0] acc_word_i, // word
    input wire logic rd_valid_o, // read strobe
    input wire logic [15:0] rd_word_o, // read word
    input wire logic wr_ack_o, // write strobe
    input wire logic range_changed_o, // change pulse
    input wire logic [1:0] conv_a_in0_range_o, // span a0
    input wire logic [1:0] conv_b_in3_range_o, // span b3
    input wire logic [1:0] conv_b_in7_range_o // span b7
);
    wire logic mp = acc_word_i[15:11] == 5'h01;
    wire logic [5:0] sp = {conv_b_in7_range_o, conv_b_in3_range_o, conv_a_in0_range_o};
    function automatic logic [1:0] dec(input logic [1:0] c);
        return (c == 2'h1) ? 2'h2 : ((c == 2'h2) ? 2'h1 : 2'h0);
    endfunction
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_wr; ce_i && acc_valid_i && acc_write_i && mp; endsequence
    sequence s_rd; ce_i && acc_valid_i && !acc_write_i && mp; endsequence
    a_write_ack: assert property (s_wr |=> wr_ack_o) else $error("write not acked");
    a_unmapped_quiet: assert property (
        ce_i && acc_valid_i && !mp |=> !wr_ack_o ##1 !rd_valid_o) else $error("unmapped answered");
    a_read_answer: assert property (
        s_rd |-> ##2 rd_valid_o && rd_word_o[15:9] == $past(acc_word_i[15:9], 2))
        else $error("bad read answer");
    a_change_flag: assert property ($changed(sp) |-> range_changed_o) else $error("no flag");
    a_reset_span: assert property ($past(rst_i) |-> sp == 6'h00) else $error("reset span");
    a_a0_decode: assert property (
        s_wr ##0 acc_word_i[15:9] == 7'h04 |-> ##2 sp[1:0] == dec($past(acc_word_i[1:0], 2)))
        else $error("a0 span");
    a_b3_decode: assert property (
        s_wr ##0 acc_word_i[15:9] == 7'h06 |-> ##2 sp[3:2] == dec($past(acc_word_i[7:6], 2)))
        else $error("b3 span");
    a_b7_decode: assert property (
        s_wr ##0 acc_word_i[15:9] == 7'h07 |-> ##2 sp[5:4] == dec($past(acc_word_i[7:6], 2)))
        else $error("b7 span");
endmodule

//--- adrr_host_model.sv
// adrr_host_model.sv: host controller issuing range register accesses.
// assumes strobes move at the falling edge; reads answer within six cycles.
`timescale 1ns/100ps
module adrr_host_model (
    input wire logic clock_i, // clock
    input wire logic rd_valid_i, // read strobe
    input wire logic [15:0] rd_word_i, // read word
    output logic acc_valid_o, // access offered
    output logic acc_write_o, // write flag
    output logic [15:0] acc_word_o // access word
);
    initial acc_valid_o = 1'b0;
    initial acc_write_o = 1'b0;
    initial acc_word_o = 16'h0000;
    task automatic put(input logic wr, input logic [15:0] w);
        @(negedge clock_i);
        acc_valid_o = 1'b1;
        acc_write_o = wr;
        acc_word_o = w;
    endtask
    task automatic idle();
        @(negedge clock_i);
        acc_valid_o = 1'b0;
        acc_word_o = ~acc_word_o; // released lines show the inverse
    endtask
    task automatic wait_rd(output logic [15:0] d, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 6 && !ok; i++) begin
            @(negedge clock_i);
            ok = rd_valid_i === 1'b1;
            d = rd_word_i;
        end
    endtask
    task automatic get(input logic [15:0] w, output logic [15:0] d, output logic ok);
        put(1'b0, w);
        idle();
        wait_rd(d, ok);
    endtask
endmodule

//--- adrr_range_regs_tb_top.sv
// adrr_range_regs_tb_top.sv: bench for the input range register bank.
// assumes host model and checker files are compiled first.
`timescale 1ns/100ps
module adrr_range_regs_tb_top;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic acc_valid_i, acc_write_i, rd_valid_o, wr_ack_o, range_changed_o, ok;
    logic [15:0] acc_word_i, rd_word_o, r;
    wire [31:0] sp;
    logic [7:0] tbl [4] = '{8'h00, 8'hAA, 8'h55, 8'h00};
    int n_errors = 0;
    int comparisons = 0;
    always #2.5 clock_i = ~clock_i;
    adrr_range_regs adrr_range_regs_inst (.clock_i, .rst_i, .ce_i, .acc_valid_i, .acc_write_i,
        .acc_word_i, .rd_valid_o, .rd_word_o, .wr_ack_o, .range_changed_o,
        .conv_a_in0_range_o(sp[1:0]), .conv_a_in1_range_o(sp[3:2]), .conv_a_in2_range_o(sp[5:4]),
        .conv_a_in3_range_o(sp[7:6]), .conv_a_in4_range_o(sp[9:8]), .conv_a_in5_range_o(sp[11:10]),
        .conv_a_in6_range_o(sp[13:12]), .conv_a_in7_range_o(sp[15:14]),
        .conv_b_in0_range_o(sp[17:16]), .conv_b_in1_range_o(sp[19:18]),
        .conv_b_in2_range_o(sp[21:20]), .conv_b_in3_range_o(sp[23:22]),
        .conv_b_in4_range_o(sp[25:24]), .conv_b_in5_range_o(sp[27:26]),
        .conv_b_in6_range_o(sp[29:28]), .conv_b_in7_range_o(sp[31:30]));
    adrr_host_model host (.clock_i, .rd_valid_i(rd_valid_o), .rd_word_i(rd_word_o),
        .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i), .acc_word_o(acc_word_i));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // a read that never answers ends the run
    task automatic chk_rd(input logic [15:0] w);
        host.get(w, r, ok);
        chk("read", {ok, r}, {1'b1, w});
        if (ok !== 1'b1) report_and_stop();
    endtask
    task automatic reset_chk();
        rst_i = 1'b1;
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        chk("reset spans", sp, 32'h0);
        for (int k = 0; k < 4; k++) chk_rd({7'h04 + k[6:0], 9'h0FF});
        $display("reset test done");
    endtask
    task automatic wr_chk(input int k, input logic [8:0] d, input logic [7:0] e);
        logic [7:0] old;
        old = sp[8*k+:8];
        host.put(1'b1, {7'h04 + k[6:0], d});
        host.idle();
        chk("ack", wr_ack_o, 1'b1);
        @(negedge clock_i);
        chk("span", sp[8*k+:8], e);
        chk("changed", range_changed_o, (old != e) ? 1'b1 : 1'b0);
        chk_rd({7'h04 + k[6:0], d});
    endtask
    task automatic t_refused();
        host.put(1'b1, 16'h1000);
        host.idle();
        chk("unmapped ack", wr_ack_o, 1'b0);
        host.get(16'h0600, r, ok);
        chk("unmapped read", ok, 1'b0);
        ce_i = 1'b0;
        host.put(1'b1, 16'h0800);
        host.idle();
        chk("frozen ack", wr_ack_o, 1'b0);
        @(negedge clock_i);
        ce_i = 1'b1;
        chk_rd(16'h081B);
        $display("refusal test done");
    endtask
    task automatic t_b2b();
        host.put(1'b1, 16'h0FE4);
        host.put(1'b0, 16'h0E00);
        chk("b2b ack", wr_ack_o, 1'b1);
        host.idle();
        host.wait_rd(r, ok);
        chk("b2b read", {ok, r}, {1'b1, 16'h0FE4});
        $display("back to back test done");
    endtask
    initial begin
        reset_chk();
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) wr_chk(k, {1'b1, {4{c[1:0]}}}, tbl[c]);
        end
        for (int k = 0; k < 4; k++) wr_chk(k, 9'h01B, 8'h24);
        $display("write tests done");
        t_refused();
        t_b2b();
        reset_chk();
        report_and_stop();
    end
endmodule
bind adrr_range_regs adrr_range_regs_properties chk_inst (.clock_i, .rst_i, .ce_i, .acc_valid_i,
    .acc_write_i, .acc_word_i, .rd_valid_o, .rd_word_o, .wr_ack_o, .range_changed_o,
    .conv_a_in0_range_o, .conv_b_in3_range_o, .conv_b_in7_range_o);
